/* File: hw/intr_accept_consts.svh */
// Constants for the interrupt acceptance and address map block.
// Assumes inclusion by bare name from the package and design file.
`ifndef INTR_ACCEPT_CONSTS_SVH
`define INTR_ACCEPT_CONSTS_SVH

`define ADDR_SPACE_LO    20'h00000
`define ADDR_SPACE_HI    20'hfffff
`define VECTOR_LO        20'h0ffdc
`define VECTOR_HI        20'h0ffff
`define ROM_TOP          20'h0ffff
`define ROM_SIZE_DEF     20'h08000
`define DFLASH_LO        20'h02400
`define DFLASH_HI        20'h02bff
`define RAM_BASE         20'h00400
`define RAM_SIZE_DEF     20'h00800
`define SFR_LO0          20'h00000
`define SFR_HI0          20'h002ff
`define SFR_LO1          20'h01300
`define SFR_HI1          20'h0147f
`define NUM_INTERNAL     14
`define NUM_EXTERNAL     6
`define NUM_SOFTWARE     4
`define TRAP_SAVE_MAX    6'd31
`define IEN_RESET        1'b0
`define SSEL_RESET       1'b0
`define PRIO_RESET       3'h0

`endif

/* File: hw/intr_accept_pkg.sv */
// Types for the interrupt acceptance and address map block.
// Assumes the constants header is on the include path.
`include "intr_accept_consts.svh"

package intr_accept_pkg;

  typedef enum logic [2:0] {
    REGION_NONE   = 3'b000,
    REGION_SFR    = 3'b001,
    REGION_RAM    = 3'b010,
    REGION_DFLASH = 3'b011,
    REGION_ROM    = 3'b100,
    REGION_VECTOR = 3'b101
  } region_t;

  typedef struct packed {
    logic       ien;
    logic       ssel;
    logic [2:0] prio;
  } flags_t;

  typedef struct packed {
    logic       valid;
    logic [4:0] source;
    logic [2:0] prio;
  } grant_t;

endpackage

/* File: hw/intr_accept.sv */
// Interrupt acceptance flags, request arbitration and memory region decode.
// Holds the enable, stack select and priority flags with a saved copy,
// picks the highest pending hardware request above the current level,
// and registers the region that the presented address falls in.
// Assumes the CPU sequencer drives strobes synchronous to clk_sys.
// Assumes requesting peripherals run on clk_sys, so no synchroniser is needed.
//
// Contract
// - Maskable requests are blocked while the enable flag is 0, allowed at 1.
// - Acknowledging any interrupt clears the enable flag; only the hardware ack clears it here, trap_exec leaves it.
// - Stack select 0 picks interrupt stack pointer, 1 picks user stack pointer.
// - Stack select clears on hardware acknowledge or trap numbers 0 to 31.
// - Processor priority level is a 3-bit field holding levels 0 to 7.
// - A request is allowed only if its priority exceeds the current level.
// - Reserved flag bit is written as 0 and reads undefined.
// - Decoder spans the whole 1 Mbyte space 00000h to FFFFFh.
// - Addresses 0FFDCh to 0FFFFh decode as the fixed vector table.
// - Program ROM ends at 0FFFFh and grows downward by its size.
// - Data flash decodes at 02400h to 02BFFh.
// - RAM starts at 00400h and grows upward; it holds the interrupt stack.
// - Register decode covers 00000h-002FFh and 01300h-0147Fh.
// - Requests come from 14 internal, 6 external and 4 software sources.
`timescale 1ns/1ps
`default_nettype none
`include "intr_accept_consts.svh"

module intr_accept
  import intr_accept_pkg::*;
#(
  parameter int          N_INT    = `NUM_INTERNAL,
  parameter int          N_EXT    = `NUM_EXTERNAL,
  parameter logic [19:0] ROM_SIZE = `ROM_SIZE_DEF,
  parameter logic [19:0] RAM_SIZE = `RAM_SIZE_DEF
) (
  // Clock and reset
  input  wire  logic                  clk_sys,
  input  wire  logic                  rst,
  // Hardware requests and their priorities
  input  wire  logic [N_INT+N_EXT-1:0] hw_req,
  input  wire  logic [3*(N_INT+N_EXT)-1:0] hw_prio,
  // Sequencer acknowledge and trap execution
  input  wire  logic                  ack,
  input  wire  logic                  trap_exec,
  input  wire  logic [5:0]            trap_num,
  // Flag writes and restore on return
  input  wire  logic                  flag_wr,
  input  wire  flags_t                flag_wdata,
  input  wire  logic                  flag_restore,
  // Address to decode
  input  wire  logic [19:0]           addr,
  // Current flags and saved copy
  output var   flags_t                flags,
  output var   flags_t                saved_flags,
  output logic                        use_user_sp,
  // Arbitration result
  output var   grant_t                grant,
  // Region decode
  output var   region_t               region,
  output logic                        sfr_hit
);

  localparam int NHW = N_INT + N_EXT;

  //////////////////////////////////////////////////////////////////////////////
  // Helpers
  function automatic logic in_range(
    input logic [19:0] a,
    input logic [19:0] lo,
    input logic [19:0] hi
  );
    begin
      in_range = (a >= lo) && (a <= hi);
    end
  endfunction

  //////////////////////////////////////////////////////////////////////////////
  // Arbitration

  logic [2:0] best_prio [NHW:0];
  logic [4:0] best_src  [NHW:0];
  logic       best_vld  [NHW:0];
  assign best_prio[0] = 3'h0;
  assign best_src[0]  = 5'h00;
  assign best_vld[0]  = 1'b0;

  genvar g;
  generate
    for (g = 0; g < NHW; g++) begin : g_arb
      wire logic [2:0] p     = hw_prio[3*g +: 3];
      wire logic       above = p > flags.prio;
      wire logic       beats = !best_vld[g] || (p > best_prio[g]);
      wire logic       take  = hw_req[g] && above && beats;
      assign best_prio[g+1] = take ? p : best_prio[g];
      assign best_src[g+1]  = take ? 5'(g) : best_src[g];
      assign best_vld[g+1]  = best_vld[g] | take;
    end
  endgenerate

  wire logic   grant_vld  = best_vld[NHW] && flags.ien;
  wire grant_t grant_next = '{
    valid:  grant_vld,
    source: best_src[NHW],
    prio:   best_prio[NHW]
  };

  //////////////////////////////////////////////////////////////////////////////
  // Flags
  wire logic trap_low = trap_num <= `TRAP_SAVE_MAX;
  wire logic trap_clr = trap_exec && trap_low;
  flags_t    flags_next;
  flags_t    saved_next;

  // Restore beats write; acknowledge and trap clears win over both
  always_comb begin
    flags_next = flags;
    if (flag_restore) begin
      flags_next = saved_flags;
    end else if (flag_wr) begin
      flags_next = flag_wdata;
    end
    if (ack) begin
      flags_next.ien  = 1'b0;
      flags_next.ssel = 1'b0;
    end
    if (trap_clr) begin
      flags_next.ssel = 1'b0;
    end
  end

  // Copy kept for the return path
  always_comb begin
    saved_next = saved_flags;
    if (ack || trap_exec) begin
      saved_next = flags;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Address decode
  wire logic [19:0] rom_lo = `ROM_TOP - ROM_SIZE + 20'h00001;
  wire logic [19:0] ram_hi = `RAM_BASE + RAM_SIZE - 20'h00001;
  wire logic hit_sfr0 = in_range(addr, `SFR_LO0, `SFR_HI0);
  wire logic hit_sfr1 = in_range(addr, `SFR_LO1, `SFR_HI1);
  wire logic hit_sfr  = hit_sfr0 || hit_sfr1;
  wire logic hit_vec  = in_range(addr, `VECTOR_LO, `VECTOR_HI);
  wire logic hit_rom  = in_range(addr, rom_lo, `ROM_TOP);
  wire logic hit_df   = in_range(addr, `DFLASH_LO, `DFLASH_HI);
  wire logic hit_ram  = in_range(addr, `RAM_BASE, ram_hi);
  wire region_t region_next = hit_sfr ? REGION_SFR    :
                              hit_vec ? REGION_VECTOR :
                              hit_rom ? REGION_ROM    :
                              hit_df  ? REGION_DFLASH :
                              hit_ram ? REGION_RAM    : REGION_NONE;

  //////////////////////////////////////////////////////////////////////////////
  // Current flags
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      flags <= '{ien: `IEN_RESET, ssel: `SSEL_RESET, prio: `PRIO_RESET};
    end else begin
      flags <= flags_next;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Saved flags
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      saved_flags <= '{ien: `IEN_RESET, ssel: `SSEL_RESET, prio: `PRIO_RESET};
    end else begin
      saved_flags <= saved_next;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Stack pointer choice
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      use_user_sp <= `SSEL_RESET;
    end else begin
      use_user_sp <= flags_next.ssel;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Grant
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      grant <= '0;
    end else begin
      grant <= grant_next;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Region
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      region <= REGION_NONE;
    end else begin
      region <= region_next;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Register area hit
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      sfr_hit <= 1'b0;
    end else begin
      sfr_hit <= hit_sfr;
    end
  end

endmodule
`default_nettype wire

/* File: tb/intr_accept_assertions.sv */
// Port checker for intr_accept.
// Bound to every intr_accept instance.
`timescale 1ns/1ps
`default_nettype none
module intr_accept_chk import intr_accept_pkg::*; (
  input wire logic    clk_sys, rst, ack, trap_exec, sfr_hit,
  input wire logic [5:0]  trap_num,
  input wire logic [19:0] addr,
  input wire flags_t  flags, saved_flags,
  input wire grant_t  grant,
  input wire region_t region
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (rst);
  AST_MASK: assert property (!flags.ien |=> !grant.valid) else $error("masked grant");
  AST_IEN: assert property (ack |=> !flags.ien) else $error("enable kept");
  AST_SSEL: assert property (ack || trap_exec && trap_num < 6'h20 |=> !flags.ssel)
    else $error("ssel kept");
  AST_PRI: assert property (grant.valid |-> grant.prio > $past(flags.prio))
    else $error("low prio grant");
  AST_VEC: assert property (addr inside {[20'h0ffdc:20'h0ffff]} |=> region == REGION_VECTOR)
    else $error("vector");
  AST_DFL: assert property (addr inside {[20'h02400:20'h02bff]} |=> region == REGION_DFLASH)
    else $error("data flash");
  AST_SFR: assert property (addr < 20'h00300 || addr inside {[20'h01300:20'h0147f]} |=> sfr_hit)
    else $error("register area");
  AST_SAVE: assert property (ack |=> saved_flags == $past(flags)) else $error("save");
  cover property (grant.valid ##1 ack);
  cover property (trap_exec);
  cover property (region == REGION_VECTOR);
endmodule
bind intr_accept intr_accept_chk intr_accept_chk_inst (.clk_sys, .rst, .ack, .trap_exec,
  .sfr_hit, .trap_num, .addr, .flags, .saved_flags, .grant, .region);
`default_nettype wire

/* File: tb/intr_src_model.sv */
// Requesting peripherals plus the sequencer that acknowledges grants.
// Assumes set_req is pulsed just after a clock edge.
`timescale 1ns/1ps
`default_nettype none
module intr_src_model import intr_accept_pkg::*; (
  input wire logic        clk_sys, rst, set_req,
  input wire logic [4:0]  src,
  input wire logic [2:0]  pri,
  input wire grant_t      grant,
  output logic     [19:0] hw_req,
  output logic     [59:0] hw_prio,
  output logic            ack
);
  // Level held until acknowledged, one ack per grant
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      hw_req <= '0;
      hw_prio <= '0;
      ack <= 1'b0;
    end else begin
      ack <= grant.valid && !ack;
      if (grant.valid && !ack) hw_req[grant.source] <= 1'b0;
      if (set_req) begin
        hw_req[src] <= 1'b1;
        hw_prio[3*src+:3] <= pri;
      end
    end
  end
endmodule
`default_nettype wire

/* File: tb/tb.sv */
// Bench for intr_accept with the source model.
// Assumes one ack per grant from the model.
`timescale 1ns/1ps
`default_nettype none
module tb;
  import intr_accept_pkg::*;
  logic clk_sys = 0, rst = 1, trap_exec = 0, flag_wr = 0, flag_restore = 0, set_req = 0;
  logic ack, use_user_sp, sfr_hit;
  logic [5:0] trap_num = '0;
  logic [4:0] src = '0;
  logic [2:0] pri = '0;
  logic [19:0] addr = '0, hw_req;
  logic [59:0] hw_prio;
  flags_t flag_wdata = '0, flags, saved_flags;
  grant_t grant;
  region_t region;
  int err_total = 0, samples_checked = 0;
  logic [19:0] ta [12] = '{20'h002ff, 20'h00300, 20'h00bff, 20'h00c00, 20'h0147f, 20'h01480,
    20'h02400, 20'h02c00, 20'h07fff, 20'h0ffdb, 20'h0ffdc, 20'hfffff};
  logic [2:0] tr [12] = '{3'h1, 3'h0, 3'h2, 3'h0, 3'h1, 3'h0, 3'h3, 3'h0, 3'h0, 3'h4, 3'h5, 3'h0};
  initial forever #12.5 clk_sys = ~clk_sys;
  intr_accept intr_accept_inst (.clk_sys, .rst, .hw_req, .hw_prio, .ack, .trap_exec, .trap_num,
    .flag_wr, .flag_wdata, .flag_restore, .addr, .flags, .saved_flags, .use_user_sp, .grant,
    .region, .sfr_hit);
  intr_src_model intr_src_model_inst (.clk_sys, .rst, .set_req, .src, .pri, .grant, .hw_req,
    .hw_prio, .ack);
  task automatic step;
    @(posedge clk_sys);
    #1;
  endtask
  task automatic chk(logic [19:0] seen, logic [19:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      err_total++;
      $display("unexpected at %0t: got %h want %h", $time, seen, exp);
    end
  endtask
  task automatic wr(flags_t f);
    flag_wr = 1;
    flag_wdata = f;
    step;
    flag_wr = 0;
  endtask
  task automatic req(logic [4:0] s, logic [2:0] p);
    set_req = 1;
    src = s;
    pri = p;
    step;
    set_req = 0;
  endtask
  task automatic trap(logic [5:0] n);
    trap_exec = 1;
    trap_num = n;
    step;
    trap_exec = 0;
  endtask
  task automatic test_done;
    $display("errors %0d checks %0d", err_total, samples_checked);
    if (err_total == 0 && samples_checked > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  initial begin
    #100000;
    err_total++;
    test_done;
  end
  initial begin
    repeat (2) @(posedge clk_sys);
    #1 rst = 0;
    chk(flags, '0);
    foreach (ta[i]) begin
      addr = ta[i];
      step;
      chk(region, tr[i]);
      chk(sfr_hit, tr[i] == 3'h1);
    end
    wr({1'b1, 1'b1, 3'h2});
    chk(use_user_sp, 1'b1);
    req(5'h03, 3'h2);
    step;
    step;
    chk(grant.valid, 1'b0);
    req(5'h10, 3'h3);
    step;
    chk(grant, {1'b1, 5'h10, 3'h3});
    step;
    step;
    chk(flags, {1'b0, 1'b0, 3'h2});
    chk(saved_flags, {1'b1, 1'b1, 3'h2});
    chk(use_user_sp, 1'b0);
    req(5'h05, 3'h7);
    step;
    step;
    chk(grant.valid, 1'b0);
    flag_restore = 1;
    step;
    flag_restore = 0;
    chk(flags, {1'b1, 1'b1, 3'h2});
    step;
    chk(grant, {1'b1, 5'h05, 3'h7});
    repeat (3) step;
    wr({1'b1, 1'b1, 3'h5});
    trap(6'h20);
    chk(flags.ssel, 1'b1);
    step;
    trap(6'h1f);
    chk(flags.ssel, 1'b0);
    chk(saved_flags, {1'b1, 1'b1, 3'h5});
    wr({1'b1, 1'b0, 3'h1});
    step;
    chk(grant, {1'b1, 5'h03, 3'h2});
    repeat (3) step;
    test_done;
  end
endmodule
`default_nettype wire
